// ---- verilog/fmhr_pkg.sv ----
// Package for the host-side register group of the FM multiplex data decoder.
// Assumes a 50 MHz system clock; every user of the map imports this package.
package fmhr_pkg;

   // Register offsets on the parallel port address lines
   localparam logic [3:0] ADDR_PACKET_DATA      = 4'h0;
   localparam logic [3:0] ADDR_PACKET_CONDITION = 4'h1;
   localparam logic [3:0] ADDR_BLOCK_INDEX      = 4'h2;
   localparam logic [3:0] ADDR_CONTROL_TWO      = 4'h5;
   localparam logic [3:0] ADDR_GROUP_CHECK      = 4'h6;

   // Reset values
   localparam logic [7:0]  CONTROL_TWO_RESET = 8'h00;
   localparam logic [7:0]  GROUP_CHECK_RESET = 8'h00;
   localparam logic [15:0] CRC_RESET         = 16'h0000;

   // Control register two field positions
   localparam int CT_DMA_ENABLE      = 0;
   localparam int CT_STROBE_SELECT   = 1;
   localparam int CT_RAW_FRAME_OUT   = 2;
   localparam int CT_READY_TIMING    = 3;
   localparam int CT_REQ_POLARITY    = 4;
   localparam int CT_ACK_POLARITY    = 5;
   localparam int CT_BLOCK_CLEAR     = 6;
   localparam int CT_SECONDARY       = 7;

   // Packet condition field positions
   localparam int PC_FULL_CORRECTION = 7;
   localparam int PC_BLOCK_LOCKED    = 6;
   localparam int PC_FRAME_LOCKED    = 5;
   localparam int PC_ERROR           = 4;
   localparam int PC_PARITY_BLOCK    = 3;
   localparam int PC_FRAME_HEAD      = 2;
   localparam int PC_GROUP_CHECK_OK  = 1;

   // Layer-4 check generator x^16 + x^12 + x^5 + 1, without the top term
   localparam logic [15:0] CRC_POLY      = 16'h1021;
   localparam logic [2:0]  CRC_LAST_BIT  = 3'h7;

   // Timing
   localparam int CLK_PERIOD_NS  = 20;
   localparam int INT_WIDTH_NS   = 2000;
   localparam int READY_HOLD_NS  = 200;
   localparam int INT_CYCLES     = (INT_WIDTH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int READY_CYCLES   = (READY_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [6:0] INT_CYC_W   = 7'(INT_CYCLES);
   localparam logic [3:0] READY_CYC_W = 4'(READY_CYCLES);

   typedef enum logic [0:0] {
      FMHR_CRC_IDLE  = 1'b0,
      FMHR_CRC_SHIFT = 1'b1
   } fmhr_crc_state_t;

   typedef enum logic [1:0] {
      FMHR_RDY_IDLE = 2'b00,
      FMHR_RDY_HOLD = 2'b01,
      FMHR_RDY_WAIT = 2'b10
   } fmhr_rdy_state_t;

endpackage : fmhr_pkg

// ---- verilog/fmhr_regs.sv ----
// Host-side register group: control register two, packet condition, block
// index and the layer-4 data-group check. Parallel port strobes arrive from
// pins and are synchronised; packet flags come from decoder logic on CLK_SYS.
//
// Contract
// R1: Control bit 0 selects DMA packet readout
// R2: Strobe select: read strobe or acknowledge
// R3: Raw frame output enable steers frame output
// R4: Ready timing bit picks ready variant
// R5: Request polarity bit: low or high active
// R6: Acknowledge polarity bit: low or high active
// R7: Block clear unlocks block sync, clears counter
// R8: During block clear: no interrupt, output released
// R9: Host writes block clear back to zero
// R10: Host sets secondary flag for substation
// R11: Offset 06H feeds bytes to group check
// R12: Condition bits: correction, block, frame lock
// R13: Error, parity, frame head bits; bit0 unused
// R14: Frame head valid only without full correction
// R15: Check bit captures all-zero just before read
// R16: Block index holds 8-bit block number
// R17: Index undefined while column fix stopped
// R18: Registers updated just before packet interrupt
// R19: Serial host may abandon after sixteen bits
// R20: Divide by x16+x12+x5+1, flag all-zero
// R21: Host clears check register before each group
// R22: Groups of any length with check word
// R23: Bytes shifted MSB first, one bit/clock
// R24: Condition and index hold between updates
`timescale 1ns/1ps
module fmhr_regs (
   input  wire logic        CLK_SYS,               // System clock, 50 MHz
   input  wire logic        SYS_RST,               // Synchronous reset, active high
   input  wire logic        CLK_EN,                // Freezes all state while low
   input  wire logic        IFACE_SERIAL,          // Pin: 1 selects the serial interface
   input  wire logic        CS_N,                  // Pin: chip select
   input  wire logic        RD_N,                  // Pin: read strobe
   input  wire logic        WR_N,                  // Pin: write strobe
   input  wire logic [3:0]  REG_ADDR,              // Pin: register address
   input  wire logic [7:0]  REG_WDATA,             // Pin: write data
   input  wire logic        TRANSFER_ACK_PIN,      // Pin: DMA acknowledge, polarity programmable
   input  wire logic        PKT_VALID,             // Decoder: new packet flags, one-cycle pulse
   input  wire logic [7:2]  PKT_FLAGS,             // Decoder: correction, lock, error, parity, head
   input  wire logic [7:0]  PKT_BLOCK,             // Decoder: block number of the packet
   input  wire logic        PKT_PENDING,           // Decoder: packet data awaits readout
   input  wire logic [7:0]  PKT_DATA,              // Decoder: current packet data byte
   input  wire logic        COLUMN_FIX_STOP,       // Control one: column correction stopped
   input  wire logic        GROUP_CHECK_CLEAR,     // Control one: hold check register at zero
   input  wire logic        SER_BYTE_VALID,        // Serial receiver: check byte strobe
   input  wire logic [7:0]  SER_BYTE,              // Serial receiver: check byte
   input  wire logic        CORE_DO_OE,            // Serial output driver wants the pin
   output logic [7:0]       RD_DATA,               // Read data to the port
   output logic             RD_DATA_OE,            // Read data drive enable
   output logic             PKT_READ_PULSE,        // To decoder: one data byte consumed
   output logic             READY_N,               // Ready pin, low while busy
   output logic             TRANSFER_REQUEST,      // DMA request pin
   output logic             INT_N,                 // Packet interrupt, active low
   output logic             GROUP_CHECK_OK,        // Check result pin, high when all zero
   output logic             SERIAL_DO_OE,          // Serial output drive enable
   output logic             BLOCK_SYNC_CLEAR,      // To sync block: unlock, clear counter
   output logic             RAW_FRAME_OUTPUT_ENABLE, // To output block: raw frame output
   output logic             SECONDARY_STATION_FLAG   // To decoder: substation reception
);
   import fmhr_pkg::*;

   typedef struct packed {
      logic [7:0]      control_two;
      logic [7:2]      packet_condition;
      logic            crc_zero;
      logic [7:0]      block_index;
      logic [15:0]     crc;
      logic [7:0]      crc_byte;
      logic [2:0]      crc_cnt;
      fmhr_crc_state_t crc_st;
      logic [2:0]      cs_s;
      logic [2:0]      rd_s;
      logic [2:0]      wr_s;
      logic [2:0]      ack_s;
      logic [2:0]      sp_s;
      logic            cs_lv;
      logic            rd_lv;
      logic            wr_lv;
      logic            ack_lv;
      logic            sp_lv;
      logic [7:0]      rd_data;
      logic            rd_oe;
      logic            pkt_read;
      fmhr_rdy_state_t rdy_st;
      logic [3:0]      rdy_cnt;
      logic            ready_n;
      logic            req;
      logic            int_pend;
      logic [6:0]      int_cnt;
      logic            int_n;
      logic            do_oe;
      logic            blk_clear;
   } fmhr_state_t;

   fmhr_state_t r;
   fmhr_state_t next_r;

   // Maps a logical level onto a pin of programmable polarity (1 = active high)
   function automatic logic fmhr_polar(input logic level, input logic active_high);
      fmhr_polar = active_high ? level : ~level;
   endfunction : fmhr_polar

   // Three-stage input filter step: the level moves only when stages one and two agree
   function automatic logic fmhr_agree(input logic [2:0] s, input logic lv);
      fmhr_agree = (s[1] == s[2]) ? s[2] : lv;
   endfunction : fmhr_agree

   logic parallel;
   logic wr_go;
   logic rd_start;
   logic rd_end;
   logic ack_act;
   logic ack_start;
   logic data_rd;
   logic byte_go;
   logic [7:0] byte_in;
   logic fb;

   // Next-state logic for the whole block
   always_comb begin
      next_r    = r;
      parallel  = 1'b0;
      wr_go     = 1'b0;
      rd_start  = 1'b0;
      rd_end    = 1'b0;
      ack_act   = 1'b0;
      ack_start = 1'b0;
      data_rd   = 1'b0;
      byte_go   = 1'b0;
      byte_in   = GROUP_CHECK_RESET;
      fb        = 1'b0;

      // Pin synchronisers; stage zero feeds stage one only
      next_r.cs_s  = {r.cs_s[1:0], CS_N};
      next_r.rd_s  = {r.rd_s[1:0], RD_N};
      next_r.wr_s  = {r.wr_s[1:0], WR_N};
      next_r.ack_s = {r.ack_s[1:0], TRANSFER_ACK_PIN};
      next_r.sp_s  = {r.sp_s[1:0], IFACE_SERIAL};
      next_r.cs_lv  = fmhr_agree(r.cs_s, r.cs_lv);
      next_r.rd_lv  = fmhr_agree(r.rd_s, r.rd_lv);
      next_r.wr_lv  = fmhr_agree(r.wr_s, r.wr_lv);
      next_r.ack_lv = fmhr_agree(r.ack_s, r.ack_lv);
      next_r.sp_lv  = fmhr_agree(r.sp_s, r.sp_lv);
      parallel = ~r.sp_lv;

      // Strobe edges, all on filtered levels
      wr_go    = parallel & r.wr_lv & ~next_r.wr_lv & ~next_r.cs_lv;
      rd_start = parallel & r.rd_lv & ~next_r.rd_lv & ~next_r.cs_lv;
      rd_end   = ~r.rd_lv & next_r.rd_lv;
      ack_act  = parallel & ~fmhr_polar(next_r.ack_lv, r.control_two[CT_ACK_POLARITY]) ? 1'b0 :
                 parallel;                                                           // R6
      ack_start = ack_act & (fmhr_polar(r.ack_lv, r.control_two[CT_ACK_POLARITY]) == 1'b0); // R6

      // Register writes; only control two and the check input are writable
      if (wr_go) begin
         case (REG_ADDR)
            ADDR_CONTROL_TWO: next_r.control_two = REG_WDATA;  // R1 R9 R10
            ADDR_GROUP_CHECK: begin
               byte_go = 1'b1;                                 // R11
               byte_in = REG_WDATA;
            end
            default: ;
         endcase
      end
      // Serial hosts feed the check through their own receiver instead
      if (~parallel && SER_BYTE_VALID) begin
         byte_go = 1'b1;                                       // R11 R22
         byte_in = SER_BYTE;
      end

      // Group check: MSB first, one bit a clock; a byte during a shift is lost
      fb = r.crc[15] ^ r.crc_byte[7];
      case (r.crc_st)
         FMHR_CRC_IDLE: begin
            if (byte_go) begin
               next_r.crc_byte = byte_in;                      // R23
               next_r.crc_cnt  = 3'h0;
               next_r.crc_st   = FMHR_CRC_SHIFT;
            end
         end
         FMHR_CRC_SHIFT: begin
            next_r.crc      = {r.crc[14:0], 1'b0} ^ (fb ? CRC_POLY : CRC_RESET); // R20
            next_r.crc_byte = {r.crc_byte[6:0], 1'b0};                          // R23
            next_r.crc_cnt  = r.crc_cnt + 3'h1;
            if (r.crc_cnt == CRC_LAST_BIT) begin
               next_r.crc_st = FMHR_CRC_IDLE;
            end
         end
         default: next_r.crc_st = FMHR_CRC_IDLE;
      endcase
      // Clear is a level from control one and overrides any shift in progress
      if (GROUP_CHECK_CLEAR) begin
         next_r.crc    = CRC_RESET;
         next_r.crc_st = FMHR_CRC_IDLE;
      end
      // All-zero flag kept in a flop so the result pin needs no compare behind it
      next_r.crc_zero = (next_r.crc == CRC_RESET);                       // R20

      // Packet readout strobe: read pin, or the acknowledge pin in DMA mode
      if (r.control_two[CT_DMA_ENABLE]) begin                             // R1
         data_rd = r.control_two[CT_STROBE_SELECT] ? ack_start :           // R2
                   (rd_start & ack_act);
      end else begin
         data_rd = rd_start & (REG_ADDR == ADDR_PACKET_DATA);
      end
      next_r.pkt_read = data_rd;

      // Register reads: data captured when the strobe opens
      if (rd_start || data_rd) begin
         next_r.rd_oe = 1'b1;
         case (REG_ADDR)
            ADDR_PACKET_CONDITION: begin
               next_r.rd_data = {r.packet_condition, r.crc_zero, 1'b0};  // R12 R13 R15
            end
            ADDR_BLOCK_INDEX: next_r.rd_data = r.block_index;            // R16 R17
            default:          next_r.rd_data = PKT_DATA;
         endcase
         if (data_rd) begin
            next_r.rd_data = PKT_DATA;
         end
      end else if (rd_end || ~parallel ||
                   (r.control_two[CT_DMA_ENABLE] && r.control_two[CT_STROBE_SELECT] && ~ack_act && r.rd_lv)) begin
         // Acknowledge-strobed reads never raise RD, so the end of the acknowledge frees the bus
         next_r.rd_oe = 1'b0;                                              // R2
      end

      // Ready: timing one follows the strobe, timing two is a fixed hold
      case (r.rdy_st)
         FMHR_RDY_IDLE: begin
            if (data_rd) begin
               next_r.ready_n = 1'b0;
               next_r.rdy_cnt = READY_CYC_W;
               next_r.rdy_st  = r.control_two[CT_READY_TIMING] ? FMHR_RDY_HOLD : // R4
                                FMHR_RDY_WAIT;
            end
         end
         FMHR_RDY_HOLD: begin
            next_r.rdy_cnt = r.rdy_cnt - 4'h1;
            if (r.rdy_cnt == 4'h1) begin
               next_r.ready_n = 1'b1;                                     // R4
               next_r.rdy_st  = FMHR_RDY_IDLE;
            end
         end
         FMHR_RDY_WAIT: begin
            if (rd_end || ~ack_act && r.control_two[CT_STROBE_SELECT]) begin
               next_r.ready_n = 1'b1;                                     // R4
               next_r.rdy_st  = FMHR_RDY_IDLE;
            end
         end
         default: begin
            next_r.ready_n = 1'b1;
            next_r.rdy_st  = FMHR_RDY_IDLE;
         end
      endcase

      // DMA request pin, meaningful only on the parallel interface
      next_r.req = fmhr_polar(parallel & r.control_two[CT_DMA_ENABLE] & PKT_PENDING, // R1
                              r.control_two[CT_REQ_POLARITY]);                       // R5

      // Packet update: registers load one cycle ahead of the interrupt edge
      next_r.int_pend = 1'b0;
      if (PKT_VALID && !r.control_two[CT_BLOCK_CLEAR]) begin
         next_r.packet_condition = PKT_FLAGS;                             // R12 R13 R14 R18
         next_r.block_index      = PKT_BLOCK;                             // R16 R18
         next_r.int_pend         = 1'b1;
      end
      if (r.int_pend) begin
         next_r.int_n   = 1'b0;                                           // R18
         next_r.int_cnt = INT_CYC_W;
      end else if (r.int_cnt != 7'h0) begin
         next_r.int_cnt = r.int_cnt - 7'h1;
         if (r.int_cnt == 7'h1) begin
            next_r.int_n = 1'b1;
         end
      end
      // Block clear silences the interrupt and releases the serial output
      if (r.control_two[CT_BLOCK_CLEAR]) begin
         next_r.int_pend = 1'b0;                                          // R8
         next_r.int_cnt  = 7'h0;
         next_r.int_n    = 1'b1;                                          // R8
      end
      next_r.do_oe     = CORE_DO_OE & ~r.control_two[CT_BLOCK_CLEAR];     // R8
      next_r.blk_clear = r.control_two[CT_BLOCK_CLEAR];                   // R7
   end

   // State register; reset levels match the idle pin states
   always_ff @(posedge CLK_SYS) begin
      if (SYS_RST) begin
         r             <= '0;
         r.control_two <= CONTROL_TWO_RESET;
         r.crc         <= CRC_RESET;
         r.crc_zero    <= 1'b1;
         r.crc_st      <= FMHR_CRC_IDLE;
         r.rdy_st      <= FMHR_RDY_IDLE;
         r.cs_s        <= 3'h7;
         r.rd_s        <= 3'h7;
         r.wr_s        <= 3'h7;
         r.ack_s       <= 3'h7;
         r.cs_lv       <= 1'b1;
         r.rd_lv       <= 1'b1;
         r.wr_lv       <= 1'b1;
         r.ack_lv      <= 1'b1;
         r.ready_n     <= 1'b1;
         r.req         <= 1'b1;
         r.int_n       <= 1'b1;
      end else if (CLK_EN) begin
         r <= next_r;                                                     // R24
      end
   end

   // Outputs straight from the state register
   assign RD_DATA                 = r.rd_data;
   assign RD_DATA_OE              = r.rd_oe;
   assign PKT_READ_PULSE          = r.pkt_read;
   assign READY_N                 = r.ready_n;
   assign TRANSFER_REQUEST        = r.req;
   assign INT_N                   = r.int_n;
   assign GROUP_CHECK_OK          = r.crc_zero;             // R20
   assign SERIAL_DO_OE            = r.do_oe;
   assign BLOCK_SYNC_CLEAR        = r.blk_clear;            // R7
   assign RAW_FRAME_OUTPUT_ENABLE = r.control_two[CT_RAW_FRAME_OUT]; // R3
   assign SECONDARY_STATION_FLAG  = r.control_two[CT_SECONDARY];

endmodule : fmhr_regs

// ---- verification/fmhr_monitor.sv ----
// Checker on the register group ports.
// Assumes CLK_EN stays high.
`timescale 1ns/1ps
module fmhr_monitor (
   input wire logic CLK_SYS,                 // Clock
   input wire logic SYS_RST,                 // Reset
   input wire logic WR_N,                    // Write strobe
   input wire logic IFACE_SERIAL,            // Serial select
   input wire logic GROUP_CHECK_CLEAR,       // Check clear
   input wire logic PKT_VALID,               // New packet
   input wire logic INT_N,                   // Interrupt
   input wire logic READY_N,                 // Ready
   input wire logic PKT_READ_PULSE,          // Byte consumed
   input wire logic TRANSFER_REQUEST,        // DMA request
   input wire logic GROUP_CHECK_OK,          // Check result
   input wire logic RD_DATA_OE,              // Read enable
   input wire logic SERIAL_DO_OE,            // Serial enable
   input wire logic BLOCK_SYNC_CLEAR,        // Block clear
   input wire logic RAW_FRAME_OUTPUT_ENABLE, // Raw output
   input wire logic SECONDARY_STATION_FLAG   // Secondary
);
   default clocking cb @(posedge CLK_SYS);
   endclocking
   default disable iff (SYS_RST);
   // Idle handshakes and an empty check register straight after reset
   chk_reset_idle: assert property ($fell(SYS_RST) |-> INT_N && READY_N && GROUP_CHECK_OK && !RD_DATA_OE)
      else $error("outputs not idle after reset");
   chk_int_cause: assert property ($fell(INT_N) |-> $past(PKT_VALID, 2))
      else $error("interrupt without packet");
   chk_int_quiet: assert property (BLOCK_SYNC_CLEAR && $past(BLOCK_SYNC_CLEAR) |-> INT_N)
      else $error("interrupt during block clear");
   chk_do_released: assert property (BLOCK_SYNC_CLEAR |-> !SERIAL_DO_OE)
      else $error("serial output driven during block clear");
   chk_clear_zero: assert property (GROUP_CHECK_CLEAR |=> GROUP_CHECK_OK)
      else $error("check register not zero after clear");
   // Serial hosts cannot reach the DMA logic, so the request must sit still
   chk_serial_req: assert property (IFACE_SERIAL [*8] |-> $stable(TRANSFER_REQUEST))
      else $error("request moved in serial mode");
   chk_hold_ctrl: assert property (WR_N [*6] |-> $stable(RAW_FRAME_OUTPUT_ENABLE) && $stable(SECONDARY_STATION_FLAG))
      else $error("control bits moved without a write");
   chk_ready_pulse: assert property ($fell(READY_N) |-> PKT_READ_PULSE)
      else $error("ready dropped without a byte read");
endmodule : fmhr_monitor
bind fmhr_regs fmhr_monitor u_mon (.CLK_SYS, .SYS_RST, .WR_N, .IFACE_SERIAL, .GROUP_CHECK_CLEAR, .PKT_VALID,
   .INT_N, .READY_N, .PKT_READ_PULSE, .TRANSFER_REQUEST, .GROUP_CHECK_OK, .RD_DATA_OE, .SERIAL_DO_OE,
   .BLOCK_SYNC_CLEAR, .RAW_FRAME_OUTPUT_ENABLE, .SECONDARY_STATION_FLAG);

// ---- verification/fmhr_host.sv ----
// Host CPU model on the parallel register port.
// Assumes tasks are entered just after a rising edge.
`timescale 1ns/1ps
module fmhr_host (
   input  wire logic       CLK_SYS,   // Clock
   output logic            CS_N,      // Chip select
   output logic            RD_N,      // Read strobe
   output logic            WR_N,      // Write strobe
   output logic [3:0]      REG_ADDR,  // Address
   output logic [7:0]      REG_WDATA, // Write data
   input  wire logic [7:0] RD_DATA    // Read data
);
   // Idle port at time zero
   initial begin
      {CS_N, RD_N, WR_N} = 3'h7;
      REG_ADDR = 4'h0;
      REG_WDATA = 8'hA5;
   end
   // Strobes stay low four edges so the pin filter sees them
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      REG_ADDR = a;
      REG_WDATA = v;
      {CS_N, WR_N} = 2'h0;
      repeat (4) @(posedge CLK_SYS);
      #1 {CS_N, WR_N} = 2'h3;
      REG_WDATA = ~v; // Released data never repeats the last value
      repeat (6) @(posedge CLK_SYS);
      #1;
   endtask : wr
   // Read data is ready four edges after the fall; taken at the sixth
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      REG_ADDR = a;
      {CS_N, RD_N} = 2'h0;
      repeat (6) @(posedge CLK_SYS);
      v = RD_DATA;
      #1 {CS_N, RD_N} = 2'h3;
      repeat (4) @(posedge CLK_SYS);
      #1;
   endtask : rd
endmodule : fmhr_host

// ---- verification/testbench.sv ----
// Self-checking bench for the host register group.
// Assumes package, design, host model and checker compiled first.
`timescale 1ns/1ps
module testbench;
   import fmhr_pkg::*;
   logic        clk_sys, sys_rst, iface_serial, ack, pkt_valid, pkt_pending, col_stop, gc_clear;
   logic        ser_valid, core_oe, cs_n, rd_n, wr_n, rd_oe, rd_pulse, ready_n, treq, int_n;
   logic        gc_ok, do_oe, bsc, raw, sec;
   logic [3:0]  reg_addr;
   logic [7:2]  flags;
   logic [7:0]  wdata, block_locked, pkt_data, ser_byte, rd_data, d, last_blk;
   logic [15:0] crc;
   logic [7:0]  mode [5] = '{8'h21, 8'h33, 8'h03, 8'h01, 8'h3B};
   logic [3:0]  probe [3] = '{4'h0, 4'h5, 4'h7};
   int          err_total, compares, pulses, n0;
   fmhr_regs u_dut (.CLK_SYS(clk_sys), .SYS_RST(sys_rst), .CLK_EN(1'b1), .IFACE_SERIAL(iface_serial),
      .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .REG_ADDR(reg_addr), .REG_WDATA(wdata), .TRANSFER_ACK_PIN(ack),
      .PKT_VALID(pkt_valid), .PKT_FLAGS(flags), .PKT_BLOCK(block_locked), .PKT_PENDING(pkt_pending), .PKT_DATA(pkt_data),
      .COLUMN_FIX_STOP(col_stop), .GROUP_CHECK_CLEAR(gc_clear), .SER_BYTE_VALID(ser_valid), .SER_BYTE(ser_byte),
      .CORE_DO_OE(core_oe), .RD_DATA(rd_data), .RD_DATA_OE(rd_oe), .PKT_READ_PULSE(rd_pulse), .READY_N(ready_n),
      .TRANSFER_REQUEST(treq), .INT_N(int_n), .GROUP_CHECK_OK(gc_ok), .SERIAL_DO_OE(do_oe),
      .BLOCK_SYNC_CLEAR(bsc), .RAW_FRAME_OUTPUT_ENABLE(raw), .SECONDARY_STATION_FLAG(sec));
   fmhr_host u_host (.CLK_SYS(clk_sys), .CS_N(cs_n), .RD_N(rd_n), .WR_N(wr_n), .REG_ADDR(reg_addr),
      .REG_WDATA(wdata), .RD_DATA(rd_data));
   // 50 MHz clock
   initial begin
      clk_sys = 1'b0;
      forever #10 clk_sys = ~clk_sys;
   end
   // Bytes consumed by the packet port
   always @(posedge clk_sys) if (rd_pulse === 1'b1) pulses++;
   task automatic tick(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask : tick
   task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp) begin
         err_total++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic test_done;
      $display("compares %0d err_total %0d", compares, err_total);
      if (err_total == 0 && compares > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : test_done
   // Division register after one byte, most significant bit first
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] b);
      for (int i = 7; i >= 0; i--) c = {c[14:0], 1'b0} ^ ((c[15] ^ b[i]) ? CRC_POLY : 16'h0000);
      return c;
   endfunction : crc_step
   // Packet from the decoder; the interrupt must follow within a few edges
   task automatic packet(input logic [7:2] f, input logic [7:0] b);
      int n;
      flags = f;
      block_locked = b;
      pkt_valid = 1'b1;
      tick(1);
      pkt_valid = 1'b0;
      for (n = 0; n < 8 && int_n !== 1'b0; n++) tick(1);
      if (n == 8) begin
         err_total++;
         test_done();
      end
   endtask : packet
   // Check byte over whichever interface is selected; gap keeps the shifter idle
   task automatic feed(input logic [7:0] b);
      crc = crc_step(crc, b);
      if (iface_serial) begin
         {ser_byte, ser_valid} = {b, 1'b1};
         tick(1);
         {ser_byte, ser_valid} = {~b, 1'b0};
         tick(10);
      end
      else u_host.wr(ADDR_GROUP_CHECK, b);
   endtask : feed
   // Random group plus its check word, then a stray byte that spoils it
   task automatic group;
      int n;
      logic [15:0] w;
      gc_clear = 1'b1;
      tick(2);
      gc_clear = 1'b0;
      crc = 16'h0000;
      n = $urandom_range(4, 1);
      repeat (n) feed(8'($urandom));
      w = crc;
      feed(w[15:8]);
      feed(w[7:0]);
      tick(10);
      check("check_ok", gc_ok, 1'b1);
      feed(8'($urandom_range(255, 1)));
      tick(10);
      check("check_bad", gc_ok, crc == 16'h0000);
   endtask : group
   initial begin
      logic [7:2] f;
      logic [7:0] b;
      {sys_rst, iface_serial, ack, pkt_valid, pkt_pending, col_stop, gc_clear, ser_valid, core_oe} = 9'h140;
      {flags, block_locked, pkt_data, ser_byte, last_blk, crc} = '0;
      {err_total, compares, pulses} = '0;
      n0 = $urandom(32'h9DA7DC4C);
      tick(12);
      sys_rst = 1'b0;
      tick(2);
      check("request_idle", treq, 1'b1);
      // Random packets with boundary block numbers
      for (int k = 0; k < 6; k++) begin
         f = (k == 1) ? 6'h02 : 6'($urandom);
         b = (k == 0) ? 8'hBD : (k == 1) ? 8'h51 : 8'($urandom_range(189));
         col_stop = (k == 4);
         packet(f, b);
         u_host.rd(ADDR_PACKET_CONDITION, d);
         check("status", d, {f, crc == 16'h0000, 1'b0});
         u_host.rd(ADDR_BLOCK_INDEX, d);
         if (!col_stop) check("index", d, b);
         u_host.rd(ADDR_PACKET_CONDITION, d);
         check("status_hold", d, {f, crc == 16'h0000, 1'b0});
         last_blk = b;
         tick(100);
      end
      col_stop = 1'b0;
      // Data port consumes a byte; write-only and unmapped places do not
      foreach (probe[i]) begin
         pkt_data = 8'($urandom);
         n0 = pulses;
         u_host.rd(probe[i], d);
         check("probe_data", d, pkt_data);
         check("probe_pulse", 8'(pulses - n0), 8'(probe[i] == ADDR_PACKET_DATA));
      end
      group();
      u_host.rd(ADDR_PACKET_CONDITION, d);
      check("status_check", d[1], crc == 16'h0000);
      // DMA modes: strobe source, acknowledge and request polarity, ready timing
      pkt_pending = 1'b1;
      foreach (mode[i]) begin
         ack = ~mode[i][5];
         u_host.wr(ADDR_CONTROL_TWO, mode[i]);
         tick(4);
         check("request", treq, mode[i][4]);
         n0 = pulses;
         ack = mode[i][5];
         tick(6);
         check("ready_busy", ready_n, !mode[i][1]);
         check("dma_drive", rd_oe, mode[i][1]);
         ack = ~mode[i][5];
         tick(6);
         check("ready_timing", ready_n, !(mode[i][1] && mode[i][3]));
         tick(8);
         check("ack_reads", 8'(pulses - n0), 8'(mode[i][1]));
         check("dma_release", rd_oe, 1'b0);
      end
      u_host.wr(ADDR_CONTROL_TWO, 8'h10);
      tick(4);
      check("request_off", treq, 1'b0);
      // Block clear withholds the interrupt and releases the serial output
      core_oe = 1'b1;
      u_host.wr(ADDR_CONTROL_TWO, 8'h40);
      check("block_clear", bsc, 1'b1);
      check("do_released", do_oe, 1'b0);
      {block_locked, pkt_valid} = {8'h55, 1'b1};
      tick(1);
      pkt_valid = 1'b0;
      tick(6);
      check("int_held", int_n, 1'b1);
      u_host.wr(ADDR_CONTROL_TWO, 8'h84);
      check("raw_out", raw, 1'b1);
      check("secondary", sec, 1'b1);
      check("do_back", do_oe, 1'b1);
      u_host.rd(ADDR_BLOCK_INDEX, d);
      check("index_kept", d, last_blk);
      // Serial host: pin writes refused, check bytes come on the serial strobe
      iface_serial = 1'b1;
      tick(8);
      u_host.wr(ADDR_CONTROL_TWO, 8'h00);
      check("serial_refuse", raw, 1'b1);
      group();
      test_done();
   end
endmodule : testbench
